// file: logic/mpit_timer.v
// Purpose: 16-bit periodic interrupt timer with apb register access
// Assumes: mode inputs come from logic on MCLK_IN; one byte register per apb word
// Notes:   apb answers with PREADY after exactly one wait cycle in the access phase
// Notes on behaviour
// - sixteen bit up-counter, free-running or wrapping at the modulo byte pair
// - reading the counter never disturbs the counting sequence
// - prescale field picks divide by 1 to 64; 110 and 111 both 64
// - overflow flag sets when counter rolls to zero after modulo match
// - counter restarts from zero on the next tick after matching modulo
// - interrupt enable gates overflow request; reset clears enable
// - flag clears only by status read with flag set then zero write
// - an overflow between read and zero write voids the clear
// - writing one to the flag leaves it set but cancels a pending clear; reset clears it
// - halt bit freezes counter; reset sets halt
// - counter-reset bit clears counter and prescaler, self clears, reads zero
// - halt and counter-reset together hold the counter at zero
// - high byte read latches low byte until low byte read
// - system reset and counter-reset clear both counter bytes
// - modulo high write inhibits flag setting until modulo low write
// - reset sets all modulo bits
// - wait mode keeps counting, blocks cpu access, interrupt can wake
// - stop mode freezes the timer, keeping all state
// - break freezes the counter
// - with break clear enable set, status clears during break stick
// - with it clear, break accesses leave status alone; clear finishes later
`timescale 1ns/1ps
`include "mpit_defines.vh"

module mpit_timer (
    input  wire        MCLK_IN,
    input  wire        ARST_N_IN,
    input  wire        PSEL_IN,
    input  wire        PENABLE_IN,
    input  wire        PWRITE_IN,
    input  wire [11:0] PADDR_IN,
    input  wire [31:0] PWDATA_IN,
    output reg  [31:0] PRDATA_OUT,
    output reg         PREADY_OUT,
    output reg         PSLVERR_OUT,
    input  wire        WAIT_MODE_IN,
    input  wire        STOP_MODE_IN,
    input  wire        BREAK_IN,
    input  wire        BREAK_CLEAR_EN_IN,
    output reg         IRQ_OUT
);

    reg [15:0]                 counter_q;
    reg [`MPIT_PRESC_W-1:0]    presc_q;
    reg [7:0]                  mod_hi_q;
    reg [7:0]                  mod_lo_q;
    reg [2:0]                  prescale_select_q;
    reg                        overflow_flag_q;
    reg                        overflow_irq_enable_q;
    reg                        counter_halt_q;
    reg                        clear_armed_q;
    reg                        flag_inhibit_q;
    reg                        low_latched_q;
    reg [7:0]                  low_buffer_q;

    // true when the word address is one of the five timer registers
    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a[1:0] == 2'b00) &&
                        (a[11:2] >= {2'b00, `MPIT_IDX_STATUS_CONTROL}) &&
                        (a[11:2] <= {2'b00, `MPIT_IDX_MODULO_LOW});
        end
    endfunction

    // mask of prescaler bits that must all be one for a counter tick
    function [`MPIT_PRESC_W-1:0] presc_mask;
        input [2:0] ps;
        begin
            case (ps)
                3'h0:    presc_mask = 6'h00;
                3'h1:    presc_mask = 6'h01;
                3'h2:    presc_mask = 6'h03;
                3'h3:    presc_mask = 6'h07;
                3'h4:    presc_mask = 6'h0f;
                3'h5:    presc_mask = 6'h1f;
                default: presc_mask = 6'h3f;
            endcase
        end
    endfunction

    wire [7:0]  idx       = PADDR_IN[9:2];
    wire        access    = PSEL_IN && PENABLE_IN;
    // wait mode closes the register file to the cpu
    // no cpu access
    wire        ok        = is_mapped(PADDR_IN) && !WAIT_MODE_IN;
    wire        done      = access && PREADY_OUT && ok;
    wire        wr        = done && PWRITE_IN;
    wire        rd        = done && !PWRITE_IN;
    wire [7:0]  wb        = PWDATA_IN[7:0];
    wire        stat_lock = BREAK_IN && !BREAK_CLEAR_EN_IN;

    wire        wr_sc     = wr && (idx == `MPIT_IDX_STATUS_CONTROL);
    wire        rd_sc     = rd && (idx == `MPIT_IDX_STATUS_CONTROL);
    wire        rd_hi     = rd && (idx == `MPIT_IDX_COUNTER_HIGH);
    wire        rd_lo     = rd && (idx == `MPIT_IDX_COUNTER_LOW);
    wire        wr_mh     = wr && (idx == `MPIT_IDX_MODULO_HIGH);
    wire        wr_ml     = wr && (idx == `MPIT_IDX_MODULO_LOW);
    wire        trst      = wr_sc && wb[`MPIT_BIT_COUNTER_RESET];

    wire        run       = !counter_halt_q && !STOP_MODE_IN && !BREAK_IN;
    wire [`MPIT_PRESC_W-1:0] mask = presc_mask(prescale_select_q);
    wire        tick      = run && ((presc_q & mask) == mask);
    wire [15:0] modulo    = {mod_hi_q, mod_lo_q};
    wire        match     = (counter_q == modulo);
    // overflow inhibited while modulo half written
    wire        ovf_set   = tick && match && !trst && !flag_inhibit_q;

    wire [7:0]  sc_read   = {overflow_flag_q, overflow_irq_enable_q, counter_halt_q,
                             1'b0, 1'b0, prescale_select_q};

    reg  [7:0]  rdata_d;
    always @* begin
        case (idx)
            `MPIT_IDX_STATUS_CONTROL: rdata_d = sc_read;
            `MPIT_IDX_COUNTER_HIGH:   rdata_d = counter_q[15:8];
            `MPIT_IDX_COUNTER_LOW:    rdata_d = low_latched_q ? low_buffer_q
                                                              : counter_q[7:0];
            `MPIT_IDX_MODULO_HIGH:    rdata_d = mod_hi_q;
            `MPIT_IDX_MODULO_LOW:     rdata_d = mod_lo_q;
            default:                  rdata_d = 8'h00;
        endcase
    end

    // apb slave: one wait cycle, then the answer with pready
    always @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT  <= 32'h0000_0000;
        end else if (access && !PREADY_OUT) begin
            PREADY_OUT  <= 1'b1;
            PSLVERR_OUT <= !ok;
            PRDATA_OUT  <= (ok && !PWRITE_IN) ? {24'h00_0000, rdata_d} : 32'h0000_0000;
        end else begin
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
        end
    end

    // counter and prescaler
    always @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            counter_q <= `MPIT_RST_COUNTER;
            presc_q   <= {`MPIT_PRESC_W{1'b0}};
        end else if (trst) begin
            // halted at zero if halt written too
            counter_q <= `MPIT_RST_COUNTER;
            presc_q   <= {`MPIT_PRESC_W{1'b0}};
        end else if (run) begin
            // wait mode does not stop counting
            presc_q <= presc_q + 6'h01;
            if (tick) begin
                counter_q <= match ? 16'h0000 : counter_q + 16'h0001;
            end
        end
    end

    // control bits, modulo registers, low byte buffer
    always @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            prescale_select_q     <= `MPIT_RST_PRESCALE;
            overflow_irq_enable_q <= 1'b0;
            counter_halt_q        <= `MPIT_RST_HALT;
            mod_hi_q              <= `MPIT_RST_MODULO;
            mod_lo_q              <= `MPIT_RST_MODULO;
            flag_inhibit_q        <= 1'b0;
            low_latched_q         <= 1'b0;
            low_buffer_q          <= 8'h00;
        end else begin
            if (wr_sc) begin
                prescale_select_q     <= wb[`MPIT_PS_MSB:`MPIT_PS_LSB];
                overflow_irq_enable_q <= wb[`MPIT_BIT_IRQ_ENABLE];
                counter_halt_q        <= wb[`MPIT_BIT_COUNTER_HALT];
            end
            if (wr_mh) begin
                mod_hi_q       <= wb;
                flag_inhibit_q <= 1'b1;
            end
            if (wr_ml) begin
                mod_lo_q       <= wb;
                flag_inhibit_q <= 1'b0;
            end
            // reads only touch the buffer, never the counter
            if (trst || rd_lo) begin
                low_latched_q <= 1'b0;
            end else if (rd_hi && !low_latched_q) begin
                low_latched_q <= 1'b1;
                low_buffer_q  <= counter_q[7:0];
            end
        end
    end

    // overflow flag and its two step clear
    always @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            overflow_flag_q <= 1'b0;
            clear_armed_q   <= 1'b0;
        end else if (ovf_set) begin
            // new overflow voids a pending clear; set beats clear
            overflow_flag_q <= 1'b1;
            clear_armed_q   <= 1'b0;
        end else if (!stat_lock) begin
            // clears during break stick when enabled
            if (wr_sc) begin
                if (clear_armed_q && !wb[`MPIT_BIT_OVERFLOW_FLAG]) begin
                    overflow_flag_q <= 1'b0;
                end
                clear_armed_q <= 1'b0;
            end else if (rd_sc && overflow_flag_q) begin
                clear_armed_q <= 1'b1;
            end
        end
    end

    // level request, also the wake source in wait mode
    always @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= (overflow_flag_q || ovf_set) && overflow_irq_enable_q;
        end
    end

endmodule

// file: pkg/mpit_defines.vh
// Purpose: constants of the modulo periodic interrupt timer
// Assumes: register index times four gives the apb byte address
// Notes:   definitions only
`ifndef MPIT_DEFINES_VH
`define MPIT_DEFINES_VH

`define MPIT_IDX_STATUS_CONTROL 8'h4b
`define MPIT_IDX_COUNTER_HIGH   8'h4c
`define MPIT_IDX_COUNTER_LOW    8'h4d
`define MPIT_IDX_MODULO_HIGH    8'h4e
`define MPIT_IDX_MODULO_LOW     8'h4f

`define MPIT_BIT_OVERFLOW_FLAG  7
`define MPIT_BIT_IRQ_ENABLE     6
`define MPIT_BIT_COUNTER_HALT   5
`define MPIT_BIT_COUNTER_RESET  4
`define MPIT_PS_MSB             2
`define MPIT_PS_LSB             0

`define MPIT_RST_PRESCALE       3'h0
`define MPIT_RST_COUNTER        16'h0000
`define MPIT_RST_MODULO         8'hff
`define MPIT_RST_HALT           1'b1
`define MPIT_PRESC_W            6

`endif

// file: test/mpit_timer_monitor.sv
// Purpose: port-level assertions for the periodic timer
// Assumes: one clock; slave answers one cycle into the access phase
// Notes:   irq may lag a flag write by one or two cycles
`timescale 1ns/1ps
module mpit_timer_monitor (
    input wire logic        MCLK_IN,
    input wire logic        ARST_N_IN,
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        PREADY_OUT,
    input wire logic        PSLVERR_OUT,
    input wire logic        WAIT_MODE_IN,
    input wire logic        STOP_MODE_IN,
    input wire logic        BREAK_IN,
    input wire logic        BREAK_CLEAR_EN_IN,
    input wire logic        IRQ_OUT
);
    wire rd_ok = PREADY_OUT && !PSLVERR_OUT && !PWRITE_IN;
    wire rd_sc = rd_ok && (PADDR_IN[9:0] == 10'h12c);
    wire wr_dn = PREADY_OUT && PSEL_IN && PWRITE_IN;
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    sequence s_wait_phase; PSEL_IN && PENABLE_IN && !PREADY_OUT; endsequence
    sequence s_one_answer; PREADY_OUT ##1 !PREADY_OUT; endsequence
    a_answer_timing: assert property (s_wait_phase |=> s_one_answer) else $error("bad ready");
    a_err_with_ready: assert property (PSLVERR_OUT |-> PREADY_OUT) else $error("lone error");
    a_read_upper_zero: assert property (rd_ok |-> PRDATA_OUT[31:8] == 24'h0) else $error("upper");
    a_reset_bit_zero: assert property (
        rd_sc |-> PRDATA_OUT[4:3] == 2'b00) else $error("reset bit read as one");
    a_irq_from_flag: assert property (
        rd_sc && PRDATA_OUT[7] && PRDATA_OUT[6] |-> IRQ_OUT) else $error("irq low");
    a_irq_needs_enable: assert property (
        rd_sc && !PRDATA_OUT[6] |-> !IRQ_OUT) else $error("irq without enable");
    a_irq_falls_write: assert property (
        $fell(IRQ_OUT) |-> $past(wr_dn) || $past(wr_dn, 2)) else $error("irq fell alone");
    a_wait_refused: assert property (
        PREADY_OUT && !PWRITE_IN && WAIT_MODE_IN && $past(WAIT_MODE_IN)
        |-> PSLVERR_OUT && PRDATA_OUT == 32'h0) else $error("wait access served");
endmodule
bind mpit_timer mpit_timer_monitor chk (.MCLK_IN(MCLK_IN), .ARST_N_IN(ARST_N_IN),
    .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .WAIT_MODE_IN(WAIT_MODE_IN), .STOP_MODE_IN(STOP_MODE_IN),
    .BREAK_IN(BREAK_IN), .BREAK_CLEAR_EN_IN(BREAK_CLEAR_EN_IN), .IRQ_OUT(IRQ_OUT));

// file: test/mpit_timer_tb.sv
// Purpose: self-checking bench for the periodic timer
// Assumes: apb slave answers after one wait cycle
// Notes:   table rows first, then the order-dependent cases
`timescale 1ns/1ps
module mpit_timer_tb;
    typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic e;} mpit_row_t;
    mpit_row_t   rows [15] = '{
        '{1'b0,12'h12c,8'h20,1'b0}, '{1'b0,12'h130,8'h00,1'b0}, '{1'b0,12'h134,8'h00,1'b0},
        '{1'b0,12'h138,8'hff,1'b0}, '{1'b0,12'h13c,8'hff,1'b0}, '{1'b0,12'h140,8'h00,1'b1},
        '{1'b0,12'h12d,8'h00,1'b1}, '{1'b1,12'h12c,8'h27,1'b0}, '{1'b0,12'h12c,8'h27,1'b0},
        '{1'b1,12'h12c,8'h35,1'b0}, '{1'b0,12'h12c,8'h25,1'b0}, '{1'b1,12'h138,8'h00,1'b0},
        '{1'b1,12'h13c,8'h05,1'b0}, '{1'b0,12'h138,8'h00,1'b0}, '{1'b0,12'h13c,8'h05,1'b0}};
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic        wmode = 1'b0, smode = 1'b0, brk = 1'b0, bce = 1'b0, pready, pslverr, irq, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [7:0]  r;
    logic [15:0] v1, v2;
    int          num_errors = 0, comparisons = 0, cyc = 0;
    always #10 clk = ~clk;
    mpit_timer uut (.MCLK_IN(clk), .ARST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .WAIT_MODE_IN(wmode),
        .STOP_MODE_IN(smode), .BREAK_IN(brk), .BREAK_CLEAR_EN_IN(bce), .IRQ_OUT(irq));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // waits one edge first so strobes never change twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk(r, x);
    endtask
    task automatic cnt(output logic [15:0] v);
        apb(1'b0, 12'h130, 8'h00);
        v[15:8] = r;
        apb(1'b0, 12'h134, 8'h00);
        v[7:0] = r;
    endtask
    task automatic finish_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            num_errors++;
            finish_test;
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk(e, rows[i].e); // refusal flag
            if (!rows[i].w)
                chk(r, rows[i].d); // values
        end
        cnt(v1); // halted count
        chk(v1, 16'h0000); // held at zero
        apb(1'b1, 12'h12c, 8'h50); // restart
        repeat (20) @(posedge clk);
        chk(irq, 1'b1); // irq level
        rc(12'h12c, 8'hc0); // flag set
        repeat (10) @(posedge clk);
        apb(1'b1, 12'h12c, 8'h40); // voided clear
        rc(12'h12c, 8'hc0); // flag kept
        for (int i = 0; i < 2; i++) begin
            {smode, brk} <= i ? 2'b01 : 2'b10;
            cnt(v1);
            repeat (10) @(posedge clk);
            cnt(v2);
            chk(v2, v1); // frozen count
        end
        apb(1'b1, 12'h12c, 8'hc0); // write one
        rc(12'h12c, 8'hc0); // flag kept
        apb(1'b1, 12'h12c, 8'h40); // protected
        rc(12'h12c, 8'hc0); // flag kept
        bce <= 1'b1;
        rc(12'h12c, 8'hc0); // arming read
        apb(1'b1, 12'h12c, 8'h40); // clear in break
        rc(12'h12c, 8'h40); // flag cleared
        chk(irq, 1'b0); // irq dropped
        brk <= 1'b0;
        wmode <= 1'b1; // halt left clear
        apb(1'b0, 12'h12c, 8'h00); // wait access
        chk(e, 1'b1); // access refused
        wmode <= 1'b0;
        apb(1'b1, 12'h12c, 8'h10); // restart before modulo
        apb(1'b1, 12'h138, 8'h00); // inhibit
        apb(1'b0, 12'h12c, 8'h00); // arming read
        apb(1'b1, 12'h12c, 8'h00); // clear
        repeat (30) @(posedge clk);
        rc(12'h12c, 8'h00); // flag held off
        apb(1'b1, 12'h13c, 8'h05); // release
        repeat (20) @(posedge clk);
        rc(12'h12c, 8'h80); // flag set
        chk(irq, 1'b0); // masked
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk(irq, 1'b0); // irq low after reset
        rc(12'h12c, 8'h20); // reset status
        rc(12'h138, 8'hff); // modulo high set
        rc(12'h13c, 8'hff); // modulo low set
        cnt(v1); // counter after reset
        chk(v1, 16'h0000); // counter cleared
        finish_test;
    end
endmodule
